// *** dv/plcr_link_partner.sv ***
`timescale 1ns/100ps
// ----
// completion path and link partner, answers after a fixed lag
// ----
module plcr_link_partner #(parameter int LAG = 3) (
   input wire logic clk_i, rst_n_i, cpl_req_i, force_detect_i,
   output logic cpl_sent_o, l0_from_detect_o
);
   int cw, lw;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cw <= 0;
         lw <= 0;
      end else begin
         cw <= cpl_req_i && !cpl_sent_o ? cw + 1 : 0;
         lw <= force_detect_i ? 1 : (lw != 0 ? lw + 1 : 0);
      end
   end
   // never instant: completion waits LAG cycles
   assign cpl_sent_o = cw == LAG;
   assign l0_from_detect_o = lw == LAG + 2;
endmodule

// *** dv/plcr_monitor.sv ***
`timescale 1ns/100ps
module plcr_monitor #(
   parameter int RETRAIN_DELAY_CYC = 20
) (
   // clock and resets
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic sticky_rst_n_i,
   // port mode
   input wire logic downstream_i,
   input wire logic upstream_i,
   // register port
   input wire logic [11:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   // completion and link
   input wire logic cpl_req_o,
   input wire logic cpl_sent_i,
   input wire logic l0_from_detect_i,
   input wire logic gen2_allowed_i,
   input wire logic prbs_step_i,
   input wire logic speed_change_o,
   input wire logic force_detect_o,
   input wire logic [15:0] prbs_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i || !sticky_rst_n_i);
   // ----
   // cycles since retrain request, wraps after long idles only
   // ----
   logic [15:0] since;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         since <= 16'h0;
      else if ($rose(cpl_req_o))
         since <= 16'h1;
      else
         since <= since + 16'h1;
   end
   a_retrain_reads_zero: assert property (
      rd_i && addr_i == 12'h540 |=> rdata_o == 32'h0) else $error("rd");
   a_cpl_before_act: assert property (
      cpl_req_o |-> !force_detect_o) else $error("early detect");
   a_retrain_cause: assert property (
      $rose(cpl_req_o) |-> $past(wr_i) && $past(addr_i) == 12'h540)
      else $error("stray retrain");
   a_dsp_prompt: assert property (
      cpl_req_o && cpl_sent_i && !upstream_i |-> ##2 force_detect_o)
      else $error("slow detect");
   a_usp_held: assert property (
      upstream_i && force_detect_o |-> since >= RETRAIN_DELAY_CYC)
      else $error("usp early");
   a_usp_bounded: assert property (
      cpl_req_o && cpl_sent_i && upstream_i |-> ##[2:60] force_detect_o)
      else $error("usp late");
   a_seed_reload: assert property (
      wr_i && addr_i == 12'h55c
      |=> {16'h0, prbs_o} == ($past(wdata_i) & 32'h0000ffff))
      else $error("seed");
   a_speed_cause: assert property (
      speed_change_o |-> $past(l0_from_detect_i) && $past(gen2_allowed_i))
      else $error("speed");
   cover property (force_detect_o && upstream_i);
   cover property (speed_change_o);
   cover property (wr_i && addr_i == 12'h55c);
endmodule
bind plcr_top plcr_monitor #(
   .RETRAIN_DELAY_CYC(RETRAIN_DELAY_CYC)
) mon (
   .clk_i(clk_i),
   .rst_n_i(rst_n_i),
   .sticky_rst_n_i(sticky_rst_n_i),
   .downstream_i(downstream_i),
   .upstream_i(upstream_i),
   .addr_i(addr_i),
   .wdata_i(wdata_i),
   .wr_i(wr_i),
   .rd_i(rd_i),
   .rdata_o(rdata_o),
   .cpl_req_o(cpl_req_o),
   .cpl_sent_i(cpl_sent_i),
   .l0_from_detect_i(l0_from_detect_i),
   .gen2_allowed_i(gen2_allowed_i),
   .prbs_step_i(prbs_step_i),
   .speed_change_o(speed_change_o),
   .force_detect_o(force_detect_o),
   .prbs_o(prbs_o)
);

// *** dv/test_plcr_top.sv ***
`timescale 1ns/100ps
module test_plcr_top;
   import plcr_pkg::*;
   localparam int DLY = 20;
   logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, upstream_i = 0;
   logic sticky_rst_n_i = 0;
   logic gen2_allowed_i = 1, downstream_i = 1, prbs_step_i = 0, seen_sc = 0;
   logic [11:0] addr_i = 12'h0;
   logic [31:0] wdata_i = 32'h0;
   logic [31:0] rdata_o;
   logic [15:0] prbs_o;
   logic cpl_req_o, cpl_sent_i, l0_from_detect_i, speed_change_o;
   logic force_detect_o;
   int fails = 0, samples_checked = 0, n;
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) if (speed_change_o) seen_sc <= 1;
   plcr_top #(.RETRAIN_DELAY_CYC(DLY)) dut (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .sticky_rst_n_i(sticky_rst_n_i),
      .downstream_i(downstream_i),
      .upstream_i(upstream_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .rdata_o(rdata_o),
      .cpl_req_o(cpl_req_o),
      .cpl_sent_i(cpl_sent_i),
      .l0_from_detect_i(l0_from_detect_i),
      .gen2_allowed_i(gen2_allowed_i),
      .prbs_step_i(prbs_step_i),
      .speed_change_o(speed_change_o),
      .force_detect_o(force_detect_o),
      .prbs_o(prbs_o)
   );
   plcr_link_partner lp (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .cpl_req_i(cpl_req_o), .force_detect_i(force_detect_o),
      .cpl_sent_o(cpl_sent_i), .l0_from_detect_o(l0_from_detect_i));
   // ----
   // access tasks
   // ----
   task automatic chk(input logic [31:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1;
      @(posedge clk_i);
      wr_i <= 0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      addr_i <= a;
      rd_i <= 1;
      @(posedge clk_i);
      rd_i <= 0;
      #1 chk(rdata_o, exp);
   endtask
   task automatic tally_and_finish();
      if (fails == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wait_fd();
      n = 0;
      while (force_detect_o !== 1'b1 && n < 200) begin
         @(posedge clk_i);
         #1 n++;
      end
      if (n == 200) begin
         fails++;
         tally_and_finish();
      end
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1;
      sticky_rst_n_i <= 1;
      repeat (2) @(posedge clk_i);
      rd(12'h55c, 32'h0000ffff);
      rd(12'h530, 32'h0);
      wr(12'h55c, 32'hbeef1234);
      #1 chk({16'h0, prbs_o}, 32'h1234);
      rd(12'h55c, 32'h00001234);
      prbs_step_i <= 1;
      repeat (5) @(posedge clk_i);
      #1 chk(prbs_o != 16'h1234, 1);
      wr(12'h55c, 32'h00005a5a);
      #1 chk({16'h0, prbs_o}, 32'h00005a5a);
      prbs_step_i <= 0;
      seen_sc = 0;
      wr(12'h540, 32'h80000000);
      rd(12'h540, 32'h0);
      wait_fd();
      chk(n < 10, 1);
      repeat (10) @(posedge clk_i);
      chk(seen_sc, 1);
      wr(12'h530, 32'h00004000);
      rd(12'h530, 32'h00004000);
      upstream_i <= 1;
      seen_sc = 0;
      wr(12'h540, 32'h80000000);
      wait_fd();
      chk(n >= DLY, 1);
      repeat (10) @(posedge clk_i);
      chk(seen_sc, 0);
      // port reset alone: control and seed must survive
      rst_n_i <= 0;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1;
      repeat (2) @(posedge clk_i);
      rd(12'h530, 32'h00004000);
      rd(12'h55c, 32'h00005a5a);
      chk({16'h0, prbs_o}, 32'h00005a5a);
      tally_and_finish();
   end
endmodule

// *** src/plcr_pkg.sv ***
package plcr_pkg;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [11:0] PLCR_CFG_UPPER_OFS = 12'h530;
   localparam logic [11:0] PLCR_STATE_CTRL_OFS = 12'h540;
   localparam logic [11:0] PLCR_PRBS_SEED_OFS = 12'h55c;
   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int PLCR_ISCC_BIT = 14;
   localparam int PLCR_RETRAIN_BIT = 31;
   localparam logic PLCR_ISCC_RST_DSP = 1'h0;
   localparam logic PLCR_ISCC_RST_OTHER = 1'h1;
   localparam logic [15:0] PLCR_SEED_RST = 16'hffff;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int PLCR_CLK_HZ = 40000000;
   localparam int PLCR_RETRAIN_DELAY_US = 1000;
   localparam int PLCR_RETRAIN_DELAY_CYC =
      (PLCR_CLK_HZ / 1000000) * PLCR_RETRAIN_DELAY_US;
   // ------------------------------------------------------------
   // retrain sequencer states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      PLCR_IDLE = 2'b00,
      PLCR_CPL = 2'b01,
      PLCR_WAIT = 2'b10,
      PLCR_FIRE = 2'b11
   } plcr_rt_state_t;
endpackage

// *** src/plcr_prbs_gen.sv ***
`timescale 1ns/100ps
module plcr_prbs_gen
   import plcr_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // control
   plcr_prbs_if.gen pif
);
   typedef struct packed {
      logic [15:0] lfsr;
   } plcr_gen_state_t;
   plcr_gen_state_t st, next_st;
   always_comb begin
      next_st = st;
      // reload wins over stepping so restart starts at the seed
      if (pif.load) begin
         next_st.lfsr = pif.seed;
      end else if (pif.step) begin
         next_st.lfsr = {st.lfsr[14:0],
            st.lfsr[15] ^ st.lfsr[14] ^ st.lfsr[12] ^ st.lfsr[3]};
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st.lfsr <= PLCR_SEED_RST;
      end else begin
         st <= next_st;
      end
   end
   assign pif.value = st.lfsr;
endmodule

// *** src/plcr_prbs_if.sv ***
`timescale 1ns/100ps
interface plcr_prbs_if;
   logic [15:0] seed;
   logic load;
   logic step;
   logic [15:0] value;
   modport ctrl (output seed, output load, output step, input value);
   modport gen (input seed, input load, input step, output value);
endinterface

// *** src/plcr_top.sv ***
`timescale 1ns/100ps
// How it works
// - with the speed change control at 0 the port asks for a gen2 speed change on its first entry to L0 from detect, if gen2 is allowed.
// - with the control at 1 no automatic gen2 change is made and the port stays at gen1.
// - the control resets to 0 on a downstream port and 1 otherwise and survives soft resets.
// - writing one to the retrain bit forces the training state machine into detect.
// - the retrain bit always reads as zero.
// - the completion of the triggering write goes out before the retrain acts.
// - on an upstream port the retrain acts 1 ms after the write and after the completion.
// - a 16-bit soft-sticky seed resetting to all ones feeds the crosslink prbs generator.
// - any change of the seed reloads the prbs counter and restarts it.
module plcr_top
   import plcr_pkg::*;
#(
   parameter int RETRAIN_DELAY_CYC = PLCR_RETRAIN_DELAY_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic sticky_rst_n_i,
   // port mode
   input wire logic downstream_i,
   input wire logic upstream_i,
   // register port
   input wire logic [11:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // completion handshake
   output logic cpl_req_o,
   input wire logic cpl_sent_i,
   // link state
   input wire logic l0_from_detect_i,
   input wire logic gen2_allowed_i,
   input wire logic prbs_step_i,
   output logic speed_change_o,
   output logic force_detect_o,
   output logic [15:0] prbs_o
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   // sticky fields sit apart so a port reset leaves them alone
   typedef struct packed {
      logic mode_seen;
      logic iscc;
      logic [15:0] seed;
   } plcr_sticky_t;
   typedef struct packed {
      logic seeded;
      logic [31:0] rdata;
      logic first_l0_done;
      logic speed_change;
      logic force_detect;
      plcr_rt_state_t rt;
      logic [31:0] cnt;
   } plcr_state_t;
   plcr_sticky_t sk, next_sk;
   plcr_state_t st, next_st;
   plcr_prbs_if pif();
   logic wr_cfg, wr_state, wr_seed;
   logic ready;
   assign wr_cfg = wr_i && addr_i == PLCR_CFG_UPPER_OFS;
   assign wr_state = wr_i && addr_i == PLCR_STATE_CTRL_OFS;
   assign wr_seed = wr_i && addr_i == PLCR_PRBS_SEED_OFS;
   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_sk = sk;
      next_st = st;
      next_st.seeded = 1'b1;
      next_st.speed_change = 1'b0;
      next_st.force_detect = 1'b0;
      // strap sampled after release; async reset loads constants only
      if (!sk.mode_seen) begin
         next_sk.mode_seen = 1'b1;
         next_sk.iscc = downstream_i ? PLCR_ISCC_RST_DSP
            : PLCR_ISCC_RST_OTHER;
      end
      if (wr_cfg) begin
         next_sk.iscc = wdata_i[PLCR_ISCC_BIT];
      end
      if (wr_seed) begin
         next_sk.seed = wdata_i[15:0];
      end
      // read decode
      next_st.rdata = 32'h0;
      if (rd_i && addr_i == PLCR_CFG_UPPER_OFS) begin
         next_st.rdata[PLCR_ISCC_BIT] = sk.iscc;
      end else if (rd_i && addr_i == PLCR_STATE_CTRL_OFS) begin
         next_st.rdata = 32'h0;
      end else if (rd_i && addr_i == PLCR_PRBS_SEED_OFS) begin
         next_st.rdata[15:0] = sk.seed;
      end
      // one-shot speed change after the first detect-to-L0
      if (l0_from_detect_i && !st.first_l0_done) begin
         next_st.first_l0_done = 1'b1;
         // gen1 kept when the control is set
         next_st.speed_change = !sk.iscc && gen2_allowed_i;
      end
      // retrain sequencer
      case (st.rt)
         PLCR_IDLE: begin
            if (wr_state && wdata_i[PLCR_RETRAIN_BIT]) begin
               next_st.rt = PLCR_CPL;
               next_st.cnt = 32'h0;
            end
         end
         PLCR_CPL: begin
            // retrain never races ahead of its completion
            if (st.cnt < 32'(RETRAIN_DELAY_CYC)) begin
               next_st.cnt = st.cnt + 32'h1;
            end
            if (cpl_sent_i) begin
               next_st.rt = upstream_i ? PLCR_WAIT : PLCR_FIRE;
            end
         end
         PLCR_WAIT: begin
            if (st.cnt >= 32'(RETRAIN_DELAY_CYC) - 32'h1) begin
               next_st.rt = PLCR_FIRE;
            end else begin
               next_st.cnt = st.cnt + 32'h1;
            end
         end
         PLCR_FIRE: begin
            next_st.force_detect = 1'b1;
            next_st.first_l0_done = 1'b0;
            next_st.rt = PLCR_IDLE;
         end
         default: begin
            next_st.rt = PLCR_IDLE;
         end
      endcase
   end
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // sticky fields only clear on the sticky reset
   always_ff @(posedge clk_i or negedge sticky_rst_n_i) begin
      if (!sticky_rst_n_i) begin
         sk.mode_seen <= 1'b0;
         sk.iscc <= PLCR_ISCC_RST_OTHER;
         sk.seed <= PLCR_SEED_RST;
      end else begin
         sk <= next_sk;
      end
   end
   // a port reset reloads the generator from the kept seed next cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st.seeded <= 1'b0;
         st.rdata <= 32'h0;
         st.first_l0_done <= 1'b0;
         st.speed_change <= 1'b0;
         st.force_detect <= 1'b0;
         st.rt <= PLCR_IDLE;
         st.cnt <= 32'h0;
      end else begin
         st <= next_st;
      end
   end
   // ------------------------------------------------------------
   // prbs generator
   // ------------------------------------------------------------
   assign ready = sk.mode_seen && st.seeded;
   assign pif.seed = wr_seed ? wdata_i[15:0] : sk.seed;
   assign pif.load = wr_seed || !ready;
   assign pif.step = prbs_step_i;
   plcr_prbs_gen u_gen (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .pif(pif)
   );
   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign rdata_o = st.rdata;
   assign cpl_req_o = st.rt == PLCR_CPL;
   assign speed_change_o = st.speed_change;
   assign force_detect_o = st.force_detect;
   assign prbs_o = pif.value;
endmodule
